// File: rtl/elcap_top.sv
// elcap_top: event/latch capture on fast inputs, APB register slave, interrupt
// assumes pins asynchronous to clk; software acting as main cyclic task reads the latch register
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module elcap_top
	import elcap_pkg::*;
#(
	parameter int N_CH = NUM_CH,
	parameter int BNC_CYC4 = BNC_C4,
	parameter int BNC_CYC5 = BNC_C5,
	parameter int BNC_CYC6 = BNC_C6,
	parameter int BNC_CYC7 = BNC_C7
) (
	input wire logic clk,
	input wire logic rst,
	input elcap_pkg::elcap_apb_req_t apb_req,
	output elcap_pkg::elcap_apb_rsp_t apb_rsp,
	input wire logic [N_CH-1:0] pin_in,
	output logic [N_CH-1:0] event_trig,
	output logic [N_CH-1:0] latched,
	output logic irq
);
	import elcap_pkg::*;

	typedef struct packed {
		elcap_apb_st_t apb_st;
		elcap_apb_rsp_t rsp;
		logic [N_CH-1:0] rd_snap;
		logic [N_CH-1:0] mode;
		logic [EDGE_FW*N_CH-1:0] edge_sel;
		logic [BNC_FW*N_CH-1:0] bounce;
		logic [N_CH-1:0] latch;
		logic [N_CH-1:0] filt_prev;
		logic [N_CH-1:0] trig;
		logic [N_CH-1:0] status;
		logic [N_CH-1:0] mask;
		logic irq;
	} elcap_top_st_t;

	elcap_top_st_t st_reg;
	elcap_top_st_t st_next;
	logic [N_CH-1:0] pin_sync;
	logic [N_CH-1:0] filt;
	logic [N_CH-1:0] rise;
	logic [N_CH-1:0] fall;
	logic [N_CH-1:0] hit;
	logic [N_CH-1:0] wmask;
	logic [N_CH-1:0] ack_clr;
	logic [DATA_W-1:0] rd_word;
	logic addr_ok;
	logic wr_done;
	logic rd_done;

	elcap_sync #(
		.W(N_CH)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.din(pin_in),
		.dout(pin_sync)
	);

	// bounce code to cycle count; the long settings are parameters so a bench can shorten them
	function automatic logic [BNC_CW-1:0] bnc_limit(input logic [BNC_SW-1:0] code);
		logic [BNC_CW-1:0] lim;
		lim = BNC_CW'(BNC_C0);
		case (code)
			3'h0: lim = BNC_CW'(BNC_C0);
			3'h1: lim = BNC_CW'(BNC_C1);
			3'h2: lim = BNC_CW'(BNC_C2);
			3'h3: lim = BNC_CW'(BNC_C3);
			3'h4: lim = BNC_CW'(BNC_CYC4);
			3'h5: lim = BNC_CW'(BNC_CYC5);
			3'h6: lim = BNC_CW'(BNC_CYC6);
			3'h7: lim = BNC_CW'(BNC_CYC7);
			default: lim = BNC_CW'(BNC_C0);
		endcase
		return lim;
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < N_CH; gi++) begin : g_ch
			logic [EDGE_FW-1:0] esel;
			assign esel = st_reg.edge_sel[gi*EDGE_FW +: EDGE_FW];
			elcap_bounce #(
				.CW(BNC_CW)
			) u_bnc (
				.clk(clk),
				.rst(rst),
				.din(pin_sync[gi]),
				.limit(bnc_limit(st_reg.bounce[gi*BNC_FW +: BNC_SW])),
				.dout(filt[gi])
			);
			assign rise[gi] = filt[gi] & ~st_reg.filt_prev[gi];
			assign fall[gi] = ~filt[gi] & st_reg.filt_prev[gi];
			// edge select gated by event mode
			assign hit[gi] = st_reg.mode[gi] & (
				(esel == ELCAP_EDGE_RISE & rise[gi]) |
				(esel == ELCAP_EDGE_FALL & fall[gi]) |
				(esel == ELCAP_EDGE_BOTH & (rise[gi] | fall[gi])));
		end
	endgenerate

	always_comb begin
		addr_ok = 1'b1;
		rd_word = ZERO_WORD;
		case (apb_req.paddr)
			OFS_MODE: rd_word[N_CH-1:0] = st_reg.mode;
			OFS_EDGE: rd_word[EDGE_FW*N_CH-1:0] = st_reg.edge_sel;
			OFS_BOUNCE: rd_word[BNC_FW*N_CH-1:0] = st_reg.bounce;
			OFS_LATCH: rd_word[N_CH-1:0] = st_reg.latch;
			OFS_LEVEL: rd_word[N_CH-1:0] = filt;
			OFS_STATUS: rd_word[N_CH-1:0] = st_reg.status;
			OFS_MASK: rd_word[N_CH-1:0] = st_reg.mask;
			default: addr_ok = 1'b0;
		endcase
	end

	assign wr_done = apb_req.psel & apb_req.penable & st_reg.rsp.pready & apb_req.pwrite & addr_ok;
	assign rd_done = apb_req.psel & apb_req.penable & st_reg.rsp.pready & ~apb_req.pwrite;
	assign wmask = apb_req.pwdata[N_CH-1:0];
	// only a completed read of the latch register, or setting the channel's mode bit to event, releases it
	// any reader of this register acts as the main task
	assign ack_clr = (rd_done && apb_req.paddr == OFS_LATCH) ? st_reg.rd_snap : '0;

	always_comb begin
		st_next = st_reg;
		st_next.filt_prev = filt;
		// apb slave: one wait cycle, then pready for a single cycle
		st_next.rsp.pready = 1'b0;
		st_next.rsp.pslverr = 1'b0;
		case (st_reg.apb_st)
			ELCAP_ST_WAIT: begin
				if (apb_req.psel && apb_req.penable) begin
					st_next.apb_st = ELCAP_ST_RESP;
					st_next.rsp.pready = 1'b1;
					st_next.rsp.pslverr = ~addr_ok;
					st_next.rsp.prdata = apb_req.pwrite ? ZERO_WORD : rd_word;
					// snapshot so only bits software actually saw get cleared
					st_next.rd_snap = st_reg.latch;
				end
			end
			ELCAP_ST_RESP: begin
				st_next.apb_st = ELCAP_ST_WAIT;
				st_next.rsp.prdata = ZERO_WORD;
			end
			default: begin
				st_next.apb_st = ELCAP_ST_WAIT;
			end
		endcase
		if (wr_done) begin
			case (apb_req.paddr)
				OFS_MODE: st_next.mode = wmask;
				OFS_EDGE: st_next.edge_sel = apb_req.pwdata[EDGE_FW*N_CH-1:0];
				OFS_BOUNCE: st_next.bounce = apb_req.pwdata[BNC_FW*N_CH-1:0];
				OFS_MASK: st_next.mask = wmask;
				default: st_next.mask = st_reg.mask;
			endcase
		end
		// sticky capture of any filtered high on a latch-mode channel
		// read clear first, then a high re-sets
		st_next.latch = ((st_reg.latch & ~ack_clr) | filt) & ~st_reg.mode;
		// trigger one cycle after the filtered edge
		st_next.trig = hit;
		st_next.status = st_reg.status;
		if (wr_done && apb_req.paddr == OFS_STATUS) begin
			st_next.status = st_reg.status & ~wmask;
		end
		// set wins over a write-one clear in the same cycle
		st_next.status = st_next.status | hit;
		st_next.irq = |(st_next.status & st_next.mask);
	end

	// latch mode and rising edge after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.apb_st <= ELCAP_ST_WAIT;
		end else begin
			st_reg <= st_next;
		end
	end

	assign apb_rsp = st_reg.rsp;
	assign event_trig = st_reg.trig;
	assign latched = st_reg.latch;
	assign irq = st_reg.irq;
endmodule // elcap_top

// File: rtl/elcap_pkg.sv
// elcap_pkg: constants, codes and carrier structs of the event/latch input capture block
// assumes a 50 MHz system clock and an APB master with 32-bit data
package elcap_pkg;
	localparam int CLK_NS = 20;
	localparam int NUM_CH = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BNC_CW = 18;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_EDGE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BOUNCE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_LATCH = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;

	// field layout: edge 2 bits per channel, bounce code 4 bits per channel (3 used)
	localparam int EDGE_FW = 2;
	localparam int BNC_FW = 4;
	localparam int BNC_SW = 3;

	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

	// debounce settings in ns, as listed
	localparam int BNC_T0_NS = 2;
	localparam int BNC_T0_SCALE = 1000;
	localparam int BNC_T0 = BNC_T0_NS * BNC_T0_SCALE;
	localparam int BNC_T1 = 4000;
	localparam int BNC_T2 = 12000;
	localparam int BNC_T3 = 40000;
	localparam int BNC_T4 = 120000;
	localparam int BNC_T5 = 400000;
	localparam int BNC_T6 = 1200000;
	localparam int BNC_T7 = 4000000;
	// least times round up to whole cycles
	localparam int BNC_C0 = (BNC_T0 + CLK_NS - 1) / CLK_NS;
	localparam int BNC_C1 = (BNC_T1 + CLK_NS - 1) / CLK_NS;
	localparam int BNC_C2 = (BNC_T2 + CLK_NS - 1) / CLK_NS;
	localparam int BNC_C3 = (BNC_T3 + CLK_NS - 1) / CLK_NS;
	localparam int BNC_C4 = (BNC_T4 + CLK_NS - 1) / CLK_NS;
	localparam int BNC_C5 = (BNC_T5 + CLK_NS - 1) / CLK_NS;
	localparam int BNC_C6 = (BNC_T6 + CLK_NS - 1) / CLK_NS;
	localparam int BNC_C7 = (BNC_T7 + CLK_NS - 1) / CLK_NS;

	// longest event latency, rounded down
	localparam int EVT_LAT_NS = 500000;
	localparam int EVT_LAT_CYC = EVT_LAT_NS / CLK_NS;

	typedef enum logic [1:0] {
		ELCAP_EDGE_RISE = 2'h0,
		ELCAP_EDGE_FALL = 2'h1,
		ELCAP_EDGE_BOTH = 2'h2
	} elcap_edge_t;

	typedef enum logic [1:0] {
		ELCAP_ST_WAIT = 2'b01,
		ELCAP_ST_RESP = 2'b10
	} elcap_apb_st_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} elcap_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} elcap_apb_rsp_t;
endpackage

// File: rtl/elcap_sync.sv
// elcap_sync: three-flop input synchroniser per bit; output moves once flops two and three agree
// assumes asynchronous pin inputs and the block clock
`timescale 1ns/1ps
module elcap_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} elcap_sync_st_t;

	elcap_sync_st_t st_reg;
	elcap_sync_st_t st_next;
	logic [W-1:0] agree;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		// first flop feeds only the second
		agree = ~(st_reg.s2 ^ st_reg.s3);
		st_next.q = (st_reg.q & ~agree) | (st_reg.s3 & agree);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.q;
endmodule // elcap_sync

// File: rtl/elcap_bounce.sv
// elcap_bounce: debounce filter; output follows input once it has stood for limit cycles
// assumes a synchronised input and a limit of at least one
`timescale 1ns/1ps
module elcap_bounce #(
	parameter int CW = 18
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	input wire logic [CW-1:0] limit,
	output logic dout
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic lvl;
	} elcap_bnc_st_t;

	elcap_bnc_st_t st_reg;
	elcap_bnc_st_t st_next;
	logic [CW-1:0] cnt_inc;

	always_comb begin
		st_next = st_reg;
		cnt_inc = st_reg.cnt + {{(CW-1){1'b0}}, 1'b1};
		// any glitch back to the held level restarts the wait
		if (din == st_reg.lvl) begin
			st_next.cnt = '0;
		end else if (cnt_inc >= limit) begin
			st_next.lvl = din;
			st_next.cnt = '0;
		end else begin
			st_next.cnt = cnt_inc;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.lvl;
endmodule // elcap_bounce

// File: verif/elcap_pins.sv
// elcap_pins: sensor model driving the fast inputs with timed high pulses
// assumes go is a one-cycle request from the bench
`timescale 1ns/1ps
module elcap_pins #(
	parameter int N = 8
) (
	input wire logic clk,
	input wire logic [N-1:0] go,
	input wire logic [15:0] width,
	output logic [N-1:0] pins
);
	logic [15:0] left = 16'h0000;
	logic [N-1:0] sel = '0;
	always @(posedge clk) begin
		if (go != '0) begin
			sel <= go;
			left <= width;
		end else if (left != 16'h0000) begin
			left <= left - 16'h0001;
		end
	end
	assign pins = (left != 16'h0000) ? sel : '0;
endmodule // elcap_pins

// File: verif/elcap_chk.sv
// elcap_chk: concurrent checks on the capture block's ports
// assumes channel 0 keeps the shortest debounce setting
`timescale 1ns/1ps
module elcap_chk
	import elcap_pkg::*;
#(
	parameter int N_CH = NUM_CH
) (
	input wire logic clk,
	input wire logic rst,
	input elcap_pkg::elcap_apb_req_t apb_req,
	input elcap_pkg::elcap_apb_rsp_t apb_rsp,
	input wire logic [N_CH-1:0] pin_in,
	input wire logic [N_CH-1:0] event_trig,
	input wire logic [N_CH-1:0] latched,
	input wire logic irq
);
	logic [7:0] low_cnt;
	wire done = apb_req.psel && apb_req.penable && apb_rsp.pready;
	// low time of pin 0; 120 covers sync plus the shortest filter
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			low_cnt <= 8'h00;
		else if (pin_in[0])
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hff)
			low_cnt <= low_cnt + 8'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_lat_rd;
		done && !apb_req.pwrite && apb_req.paddr == OFS_LATCH;
	endsequence
	a_latch_hold: assert property (!done && !$past(done) |=> (latched & $past(latched)) == $past(latched))
		else $error("latched bit dropped without read");
	a_latch_clear: assert property (s_lat_rd ##0 low_cnt > 8'h78 |=> !latched[0])
		else $error("latch read did not clear");
	a_trig_pulse: assert property (event_trig != '0 |=> (event_trig & $past(event_trig)) == '0)
		else $error("event trigger longer than one cycle");
	a_trig_nolatch: assert property ((event_trig & latched) == '0)
		else $error("event channel shows latch");
	a_irq_cause: assert property ($rose(irq) && !$past(done) && !$past(done, 2) |-> event_trig != '0)
		else $error("irq rose without event");
	a_rst_quiet: assert property ($past(rst) |-> latched == '0 && event_trig == '0 && !irq)
		else $error("outputs not idle after reset");
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	a_answer_time: assert property (apb_req.psel && apb_req.penable && !$past(apb_req.penable) |=> apb_rsp.pready)
		else $error("pready late");
endmodule // elcap_chk

// File: verif/elcap_top_bench.sv
// elcap_top_bench: directed scenarios for latch, debounce, event and interrupt
// assumes the sensor model drives the pins and the bench acts as main task
`timescale 1ns/1ps
module elcap_top_bench;
	import elcap_pkg::*;
	logic clk = 0;
	logic rst = 1;
	elcap_apb_req_t req = '0;
	elcap_apb_rsp_t rsp;
	logic [7:0] pins, trig, lat, go = 8'h00;
	logic tc_clr = 1'b0;
	logic irq;
	logic [15:0] wid = 16'h0000;
	int fails = 0, samples_checked = 0, tc[4];
	always #10 clk = ~clk;
	// one writer for the trigger tally; scenarios clear it through tc_clr
	always @(posedge clk) for (int i = 0; i < 4; i++) tc[i] <= tc_clr ? 0 : tc[i] + trig[i];
	elcap_pins i_elcap_pins(.clk(clk), .go(go), .width(wid), .pins(pins));
	elcap_top i_elcap_top(.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .pin_in(pins),
		.event_trig(trig), .latched(lat), .irq(irq));
	task conclude;
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		// an idle edge between transfers, so psel is never assigned twice in one step
		@(posedge clk);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			conclude();
		end
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r, x);
	endtask
	task pulse(input logic [7:0] m, input logic [15:0] w, input int settle);
		wid <= w;
		go <= m;
		@(posedge clk);
		go <= 8'h00;
		repeat (settle) @(posedge clk);
	endtask
	task t_defaults;
		logic [31:0] r;
		logic e;
		rd(OFS_MODE, 32'h0000_0000);
		rd(OFS_EDGE, 32'h0000_0000);
		rd(OFS_BOUNCE, 32'h0000_0000);
		rd(OFS_MASK, 32'h0000_0000);
		apb(1'b0, 8'h40, 32'h0000_0000, r, e);
		chk(e, 1);
	endtask
	task t_latch;
		pulse(8'h01, 16'd150, 300);
		chk(lat, 32'h0000_0001);
		pulse(8'h00, 16'd0, 200);
		chk(lat, 32'h0000_0001);
		// only this main-task role reads the latch register
		rd(OFS_LATCH, 32'h0000_0001);
		rd(OFS_LATCH, 32'h0000_0000);
		pulse(8'h01, 16'd1000, 300);
		rd(OFS_LATCH, 32'h0000_0001);
		chk(lat, 32'h0000_0001);
		rd(OFS_LEVEL, 32'h0000_0001);
		repeat (900) @(posedge clk);
		rd(OFS_LATCH, 32'h0000_0001);
		rd(OFS_LATCH, 32'h0000_0000);
		// second module's channels latch too
		pulse(8'hf0, 16'd150, 300);
		chk(lat, 32'h0000_00f0);
		rd(OFS_LATCH, 32'h0000_00f0);
	endtask
	task t_bounce;
		// channel 3: 4 us filter, falling edge code ignored in latch mode
		wr(OFS_BOUNCE, 32'h0000_1000);
		wr(OFS_EDGE, 32'h0000_0040);
		pulse(8'h08, 16'd150, 400);
		chk(lat, 32'h0000_0000);
		pulse(8'h08, 16'd300, 400);
		chk(lat, 32'h0000_0008);
		rd(OFS_LATCH, 32'h0000_0008);
	endtask
	task t_event;
		int n;
		wr(OFS_MASK, 32'h0000_00ff);
		wr(OFS_EDGE, 32'h0000_00e4);
		wr(OFS_MODE, 32'h0000_000f);
		tc_clr <= 1'b1;
		go <= 8'h0f;
		wid <= 16'd200;
		@(posedge clk);
		tc_clr <= 1'b0;
		go <= 8'h00;
		n = 0;
		while (trig[0] !== 1'b1 && n <= EVT_LAT_CYC) begin
			@(posedge clk);
			n++;
		end
		chk(n <= EVT_LAT_CYC, 1);
		if (n > EVT_LAT_CYC)
			conclude();
		repeat (400) @(posedge clk);
		chk({tc[3][7:0], tc[2][7:0], tc[1][7:0], tc[0][7:0]}, 32'h0002_0101);
		chk(lat, 32'h0000_0000);
		chk(irq, 1);
		rd(OFS_STATUS, 32'h0000_0007);
		wr(OFS_STATUS, 32'h0000_0007);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		wr(OFS_MASK, 32'h0000_0000);
		pulse(8'h01, 16'd200, 400);
		chk(irq, 0);
		rd(OFS_STATUS, 32'h0000_0001);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_defaults();
		t_latch();
		t_bounce();
		t_event();
		conclude();
	end
endmodule // elcap_top_bench
bind elcap_top elcap_chk #(.N_CH(N_CH)) i_elcap_chk(.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.pin_in(pin_in), .event_trig(event_trig), .latched(latched), .irq(irq));
